// ### verilog/pdssp_pkg.sv
/*
 * Shared constants and types for the pipelined double-cycle-deselect
 * synchronous memory port: array geometry, reset values and the
 * one-hot control state encoding.
 * Assumes one clock domain and an asynchronous active-high reset.
 */
package pdssp_pkg;

	// Word address width, 128K locations.
	localparam int ADDR_W = 17;
	// Data word width and byte lane geometry.
	localparam int DATA_W = 32;
	localparam int LANE_N = 4;
	localparam int LANE_W = 8;
	// Number of word locations in the array.
	localparam int DEPTH = 131072;
	// Width of the burst counter and the upper address part.
	localparam int BURST_W = 2;
	localparam int HI_W = ADDR_W - BURST_W;

	// Values after reset, and the counter step of one.
	localparam logic [HI_W-1:0] HI_RST = 15'h0000;
	localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
	localparam logic [BURST_W-1:0] STEP_ONE = 2'h1;
	localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

	// Byte lane masks.
	localparam logic [LANE_N-1:0] LANES_ALL = 4'hf;
	localparam logic [LANE_N-1:0] LANES_NONE = 4'h0;

	// Control state: deselected, inside a burst, or asleep.
	typedef enum logic [2:0] {
		PDSSP_ST_IDLE = 3'b001,
		PDSSP_ST_BURST = 3'b010,
		PDSSP_ST_SLEEP = 3'b100
	} pdssp_state_t;

endpackage : pdssp_pkg

// ### verilog/pdssp_array.sv
/*
 * Byte-lane storage array with a registered read port and a
 * self-timed write port that needs only the registered controls.
 * Assumes that write and read never target the same cycle, which the
 * controlling port guarantees.
 */
`timescale 1ns/1ps
`default_nettype none

module pdssp_array
	import pdssp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [LANE_N-1:0] wr_lanes,
	input wire logic [ADDR_W-1:0] acc_addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic rd_en,
	output logic [DATA_W-1:0] rd_data
);

	// One storage column per byte lane, so a lane write never touches
	// its neighbours and each column has a single writer.
	genvar i;
	generate
		for (i = 0; i < LANE_N; i++) begin : g_lane
			// Storage for this byte lane; not reset, contents are random.
			logic [LANE_W-1:0] mem [DEPTH];

			// Write the lane when its enable is set.
			always_ff @(posedge sys_clk) begin
				if (wr_lanes[i]) begin
					mem[acc_addr] <= wr_data[i*LANE_W +: LANE_W];
				end
			end

			// Output register of this lane, loaded only on reads.
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					rd_data[i*LANE_W +: LANE_W] <= DATA_RST[i*LANE_W +: LANE_W];
				end else if (rd_en) begin
					rd_data[i*LANE_W +: LANE_W] <= mem[acc_addr];
				end
			end
		end
	endgenerate

endmodule : pdssp_array

`default_nettype wire

// ### verilog/pdssp_port.sv
/*
 * Synchronous host port of a 128K x 32 pipelined memory with double
 * cycle deselect: input capture, address strobes, two-bit burst
 * counter, byte writes, pipelined read data and bus drive control.
 * Assumes the host runs on sys_clk and drives every synchronous
 * input from its own flip-flops; the data pin is split into in, out
 * and an active-low enable that the surrounding pad logic resolves.
 */
`timescale 1ns/1ps
`default_nettype none

module pdssp_port
	import pdssp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic proc_addr_strobe_n,
	input wire logic ctrl_addr_strobe_n,
	input wire logic burst_advance_n,
	input wire logic pipe_chip_enable_n,
	input wire logic depth_chip_enable_hi,
	input wire logic depth_chip_enable_lo_n,
	input wire logic [LANE_N-1:0] byte_lane_select_n,
	input wire logic byte_write_enable_n,
	input wire logic all_bytes_write_n,
	input wire logic out_enable_n,
	input wire logic sleep_request,
	input wire logic burst_linear,
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe_n
);

	// Synchronisers for the two pins that are not timed to sys_clk.
	logic sleep_s1_q;
	logic sleep_s2_q;
	logic linear_s1_q;
	logic linear_q;

	// Control state and burst counter registers.
	pdssp_state_t state_q;
	pdssp_state_t state_d;
	logic [HI_W-1:0] hi_q;
	logic [HI_W-1:0] hi_d;
	logic [BURST_W-1:0] base_q;
	logic [BURST_W-1:0] base_d;
	logic [BURST_W-1:0] step_q;
	logic [BURST_W-1:0] step_d;

	// Registered access stage feeding the array.
	logic [ADDR_W-1:0] acc_addr_q;
	logic [LANE_N-1:0] acc_lanes_q;
	logic acc_rd_q;
	logic [DATA_W-1:0] wdata_q;

	// Output pipeline: read data valid, then the deselect hold cycle.
	logic out_vld_q;
	logic hold_q;

	// The sleep and order pins come from outside the clock domain, so
	// each passes two flip-flops before anything looks at it.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sleep_s1_q <= 1'b0;
			sleep_s2_q <= 1'b0;
			linear_s1_q <= 1'b0;
			linear_q <= 1'b0;
		end else begin
			sleep_s1_q <= sleep_request;
			sleep_s2_q <= sleep_s1_q;
			linear_s1_q <= burst_linear;
			linear_q <= linear_s1_q;
		end
	end

	// The sleep pin has a pull-down at the pad, so an open pin reads
	// as awake; no access starts while asleep and the array keeps its
	// contents because nothing writes it.
	wire awake = !sleep_s2_q;

	// Selection needs all three enables active at the same edge.
	wire chip_sel = !pipe_chip_enable_n && depth_chip_enable_hi
		&& !depth_chip_enable_lo_n;

	// The processor strobe counts only while the first enable is low.
	wire proc_load = awake && !proc_addr_strobe_n
		&& !pipe_chip_enable_n;

	// The controller strobe is disregarded when the processor one acts.
	wire ctrl_load = awake && !ctrl_addr_strobe_n && !proc_load;

	// Address and enables are taken only on a strobe edge.
	wire any_load = proc_load || ctrl_load;

	// A burst continues only in the burst state with no new load.
	wire in_burst = (state_q == PDSSP_ST_BURST);
	wire continue_cyc = awake && in_burst && !any_load;

	// Advance is looked at only when no strobe loads this edge.
	wire advance = continue_cyc && !burst_advance_n;

	// Lane mask: global write beats the byte controls, otherwise the
	// byte enable qualifies the four active-low lane selects.
	wire [LANE_N-1:0] byte_lanes = !byte_write_enable_n
		? ~byte_lane_select_n : LANES_NONE;
	wire [LANE_N-1:0] lanes_req = !all_bytes_write_n
		? LANES_ALL : byte_lanes;
	wire wr_req = (lanes_req != LANES_NONE);

	// Counter next values: a load copies the low address bits and
	// clears the step; an advance steps by one, wrapping after four.
	assign hi_d = any_load ? addr[ADDR_W-1:BURST_W] : hi_q;
	assign base_d = any_load ? addr[BURST_W-1:0] : base_q;
	assign step_d = any_load ? BURST_RST
		: (advance ? step_q + STEP_ONE : step_q);

	// Low address of this access in the order that the user picked.
	wire [BURST_W-1:0] low_lin = base_d + step_d;
	wire [BURST_W-1:0] low_int = base_d ^ step_d;
	wire [BURST_W-1:0] low_d = linear_q ? low_lin : low_int;

	// An access happens on a selecting load or any cycle of a burst.
	wire acc_go = (any_load && chip_sel) || continue_cyc;

	// A selecting processor strobe cycle is always a read; writes start either
	// with the controller strobe or on a following burst cycle.
	wire wr_go = acc_go && !proc_load && wr_req;
	wire rd_go = acc_go && !wr_go;

	// Next control state: sleep wins, a load selects or deselects,
	// and otherwise the state holds.
	always_comb begin
		state_d = state_q;
		case (state_q)
			PDSSP_ST_SLEEP: begin
				// Leave sleep deselected; a strobe must open a burst.
				if (awake) begin
					state_d = PDSSP_ST_IDLE;
				end
			end
			PDSSP_ST_IDLE,
			PDSSP_ST_BURST: begin
				if (!awake) begin
					state_d = PDSSP_ST_SLEEP;
				end else if (any_load) begin
					state_d = chip_sel ? PDSSP_ST_BURST : PDSSP_ST_IDLE;
				end
			end
			default: begin
				// Recover from a corrupted code into the safe state.
				state_d = PDSSP_ST_IDLE;
			end
		endcase
	end

	// Control state and counter registers.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= PDSSP_ST_IDLE;
			hi_q <= HI_RST;
			base_q <= BURST_RST;
			step_q <= BURST_RST;
		end else begin
			state_q <= state_d;
			hi_q <= hi_d;
			base_q <= base_d;
			step_q <= step_d;
		end
	end

	// Access stage: every synchronous input that matters is caught
	// here at the rising edge, so the array sees only flops.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			acc_addr_q <= {HI_RST, BURST_RST};
			acc_lanes_q <= LANES_NONE;
			acc_rd_q <= 1'b0;
			wdata_q <= DATA_RST;
		end else begin
			acc_addr_q <= {hi_d, low_d};
			acc_lanes_q <= wr_go ? lanes_req : LANES_NONE;
			acc_rd_q <= rd_go;
			wdata_q <= dq_in;
		end
	end

	// Array: writes finish one edge after capture with no further
	// host timing, reads fill the output register one edge later.
	pdssp_array u_array (
		.sys_clk(sys_clk),
		.rst(rst),
		.wr_lanes(acc_lanes_q),
		.acc_addr(acc_addr_q),
		.wr_data(wdata_q),
		.rd_en(acc_rd_q),
		.rd_data(dq_out)
	);

	// Output pipeline. The extra enable stage keeps the drivers on for
	// one more cycle after the last read word, which lets a second
	// bank take the bus without a dead cycle; the cost is that a write
	// right after a read must wait that cycle before driving data.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			out_vld_q <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			out_vld_q <= acc_rd_q;
			hold_q <= out_vld_q;
		end
	end

	// Bus drive. The output enable pin gates the drivers directly and
	// is never registered, so it acts within the cycle. In the first clock
	// after a deselect in which a read address sits in the access stage, no
	// valid word exists yet, so the bus stays undriven then whatever the pin says.
	wire drive_window = out_vld_q || hold_q;
	assign dq_oe_n = !(drive_window && !out_enable_n);

	// Checks run on the one clock and are off during reset.
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// A selecting load presents the strobed address to the array.
	a_load_addr_capture: assert property (any_load && chip_sel
		|=> acc_addr_q == $past(addr))
		else $error("Loaded address not presented to the array.");

	// Global write forces all four lanes on a controller write.
	a_global_all_lanes: assert property (ctrl_load && chip_sel
		&& !all_bytes_write_n |=> acc_lanes_q == LANES_ALL)
		else $error("Global write did not select all lanes.");

	// Byte writes take exactly the selected lanes.
	a_byte_lane_mask: assert property (ctrl_load && chip_sel
		&& all_bytes_write_n && !byte_write_enable_n
		|=> acc_lanes_q == ~$past(byte_lane_select_n))
		else $error("Byte write lanes differ from lane selects.");

	// A selecting processor strobe cycle reads and never writes.
	a_proc_strobe_read: assert property (proc_load && chip_sel
		|=> acc_rd_q && acc_lanes_q == LANES_NONE)
		else $error("Processor strobe cycle did not read.");

	// With the first enable high and no controller strobe, an idle
	// port starts no access.
	a_pipe_ce_gate: assert property (!in_burst
		&& pipe_chip_enable_n && ctrl_addr_strobe_n
		|=> !acc_rd_q && acc_lanes_q == LANES_NONE)
		else $error("Access started with first enable high.");

	// Read data follows one edge later and drive holds one more.
	a_read_pipeline: assert property (acc_rd_q
		|=> out_vld_q ##1 hold_q)
		else $error("Read pipeline or deselect hold broken.");

	// The first read clock after a deselect leaves the bus undriven.
	a_first_clk_quiet: assert property (acc_rd_q && !out_vld_q
		&& !hold_q |-> dq_oe_n)
		else $error("Bus driven in first read clock.");

	// An advance steps the counter by one, modulo four.
	a_advance_step: assert property (advance
		|=> step_q == BURST_W'($past(step_q) + STEP_ONE))
		else $error("Burst counter did not step on advance.");

	// Interleaved order forms the address by XOR with the step.
	a_interleave_order: assert property (advance && !linear_q
		|=> acc_addr_q[1:0] == (base_q ^ step_q))
		else $error("Interleaved burst address wrong.");

	// While asleep no access reaches the array.
	a_sleep_quiet: assert property (sleep_s2_q
		|=> !acc_rd_q && acc_lanes_q == LANES_NONE)
		else $error("Access started during sleep.");

	// A high output enable pin always turns the drivers off.
	a_oe_direct: assert property (out_enable_n
		|-> dq_oe_n)
		else $error("Bus driven with output enable high.");

endmodule : pdssp_port

`default_nettype wire

// ### test/pdssp_host_model.sv
/*
 * Bus master model on the data bus of the memory port: resolves the
 * shared data wire from both parties' drive enables.
 * Assumes the bench drives the host's request lines itself.
 */
`timescale 1ns/1ps
`default_nettype none

module pdssp_host_model
	import pdssp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [DATA_W-1:0] dq_out,
	input wire logic dq_oe_n,
	input wire logic host_drive,
	input wire logic [DATA_W-1:0] host_data,
	output logic [DATA_W-1:0] dq_in,
	output logic bus_clash
);
	// Floating value: flips every cycle so a stale word never reads back as valid.
	logic [DATA_W-1:0] float_q = 32'h0000_0000;

	// A released wire shows the inverse of its last level, then keeps toggling.
	always @(posedge sys_clk) begin
		float_q <= ~dq_in;
	end

	// The device owns the wire while its enable is low, else the host may drive it.
	assign dq_in = !dq_oe_n ? dq_out : (host_drive ? host_data : float_q);
	// Both parties driving at once is a fault the bench must see.
	assign bus_clash = !dq_oe_n && host_drive;
endmodule : pdssp_host_model

`default_nettype wire

// ### test/pdssp_port_bench.sv
/*
 * Self-checking bench for the memory port: burst writes, linear and
 * interleaved read bursts, byte writes, strobe priority and sleep.
 * Assumes the port's package and the host model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module pdssp_port_bench
	import pdssp_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] addr = 17'h00000;
	logic proc_n = 1'b1, ctrl_n = 1'b1, step_n = 1'b1, pipe_ce_n = 1'b0, all_wr_n = 1'b1;
	// Byte write enable idles off; the two depth enables idle at their selecting levels.
	logic lane_wr_n = 1'b1, depth_hi = 1'b1, depth_lo_n = 1'b0;
	logic [LANE_N-1:0] sel_n = 4'hf;
	logic oe_n = 1'b0, sleep = 1'b0, linear = 1'b1, host_drive = 1'b0, bus_clash;
	logic [DATA_W-1:0] host_data = 32'h0000_0000, dq_in, dq_out;
	logic dq_oe_n;
	// Bench copy of the low words, kept from what was written.
	logic [DATA_W-1:0] shadow [0:7];
	int errors = 0;
	int total_checks = 0;

	always #5 sys_clk = ~sys_clk;

	pdssp_port u_dut (.sys_clk(sys_clk), .rst(rst), .addr(addr), .proc_addr_strobe_n(proc_n),
		.ctrl_addr_strobe_n(ctrl_n), .burst_advance_n(step_n), .pipe_chip_enable_n(pipe_ce_n),
		.depth_chip_enable_hi(depth_hi), .depth_chip_enable_lo_n(depth_lo_n),
		.byte_lane_select_n(sel_n), .byte_write_enable_n(lane_wr_n),
		.all_bytes_write_n(all_wr_n), .out_enable_n(oe_n), .sleep_request(sleep),
		.burst_linear(linear), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n));

	pdssp_host_model u_host (.sys_clk(sys_clk), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
		.host_drive(host_drive), .host_data(host_data), .dq_in(dq_in), .bus_clash(bus_clash));

	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run

	task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_word

	task automatic check_flag(input logic got, input logic exp);
		check_word({31'h0, got}, {31'h0, exp});
	endtask : check_flag

	// Burst address for a step; the two low bits wrap inside the burst.
	function automatic logic [ADDR_W-1:0] seq_addr(input logic [ADDR_W-1:0] b,
		input logic [1:0] s, input logic lin);
		seq_addr = {b[ADDR_W-1:2], lin ? b[1:0] + s : b[1:0] ^ s};
	endfunction : seq_addr

	// Deselect by a controller strobe with the first enable off, then idle
	// with a processor strobe low that the high first enable must mask.
	task automatic deselect();
		@(negedge sys_clk);
		{ctrl_n, pipe_ce_n, step_n, all_wr_n, lane_wr_n, host_drive} = 6'h1e;
		{proc_n, sel_n} = 5'h1f;
		@(negedge sys_clk);
		{ctrl_n, pipe_ce_n, proc_n} = 3'h6;
	endtask : deselect

	// Four global writes in one burst, words stepping by the advance input.
	// Only the low eight words are mirrored; a high burst must not alias them.
	task automatic write_burst(input logic [ADDR_W-1:0] base);
		logic [ADDR_W-1:0] a;
		for (int i = 0; i < 4; i++) begin
			@(negedge sys_clk);
			{ctrl_n, proc_n, pipe_ce_n, addr} = {i != 0, 2'h2, base};
			// Advance is low on the load edge too, where it must be ignored.
			{all_wr_n, host_drive, step_n} = 3'h2;
			host_data = {base[ADDR_W-1:BURST_W], 15'h5a00, 2'(i)};
			a = seq_addr(base, i, linear);
			if (a < 17'h00008) shadow[a[2:0]] = host_data;
		end
		deselect();
	endtask : write_burst

	// One write cycle; no_wr marks a cycle that must leave the array alone.
	// The host waits out the read hold cycle before it drives the data wire.
	task automatic write_lanes(input logic [2:0] a, input logic [3:0] s, input logic be,
		input logic [DATA_W-1:0] d, input logic both, input logic no_wr);
		@(negedge sys_clk);
		while (dq_oe_n !== 1'b1) @(negedge sys_clk);
		{ctrl_n, proc_n, pipe_ce_n, addr, sel_n} = {1'b0, !both, 1'b0, 14'h0, a, s};
		{lane_wr_n, host_drive, host_data} = {be, 1'b1, d};
		for (int b = 0; b < LANE_N; b++) begin
			if (!no_wr && !be && !s[b]) shadow[a][8*b+:8] = d[8*b+:8];
		end
		deselect();
	endtask : write_lanes

	// Read burst of four words; ign holds a processor strobe that must be ignored.
	task automatic read_burst(input logic [ADDR_W-1:0] base, input logic lin, input logic ign);
		logic [ADDR_W-1:0] a;
		@(negedge sys_clk);
		{proc_n, pipe_ce_n, addr} = {2'h0, base};
		@(negedge sys_clk);
		check_flag(dq_oe_n, 1'b1);
		{proc_n, pipe_ce_n, step_n} = {!ign, ign, 1'b0};
		for (int i = 0; i < 4; i++) begin
			@(negedge sys_clk);
			a = seq_addr(base, i, lin);
			check_word(dq_out, shadow[a[2:0]]);
			check_flag(dq_oe_n, 1'b0);
			if (i == 1) begin
				oe_n = 1'b1;
				#1 check_flag(dq_oe_n, 1'b1);
				oe_n = 1'b0;
			end
			if (i == 2) {proc_n, ctrl_n, pipe_ce_n, step_n} = 4'hb;
			if (i == 3) {ctrl_n, pipe_ce_n} = 2'h2;
		end
		@(negedge sys_clk);
		check_flag(dq_oe_n, 1'b0);
		@(negedge sys_clk);
		check_flag(dq_oe_n, 1'b1);
	endtask : read_burst

	// Any cycle with both parties on the data wire is an error.
	always @(negedge sys_clk) begin
		if (bus_clash !== 1'b0) check_flag(bus_clash, 1'b0);
	end

	// Watchdog: the whole sequence needs well under a thousand cycles.
	initial begin
		#100000;
		errors++;
		complete_run();
	end

	initial begin
		repeat (12) @(negedge sys_clk);
		rst = 1'b0;
		repeat (3) @(negedge sys_clk);
		check_word(dq_out, DATA_RST);
		check_flag(dq_oe_n, 1'b1);
		write_burst(17'h00000);
		write_burst(17'h1fffc);
		read_burst(17'h00001, 1'b1, 1'b0);
		linear = 1'b0;
		repeat (4) @(negedge sys_clk);
		read_burst(17'h00002, 1'b0, 1'b1);
		write_lanes(3'h1, 4'ha, 1'b0, 32'haabb_ccdd, 1'b0, 1'b0);
		write_lanes(3'h2, 4'h0, 1'b1, 32'h1234_5678, 1'b0, 1'b1);
		write_lanes(3'h3, 4'h0, 1'b0, 32'h8765_4321, 1'b1, 1'b1);
		sleep = 1'b1;
		repeat (4) @(negedge sys_clk);
		write_lanes(3'h0, 4'h0, 1'b0, 32'hdead_0000, 1'b0, 1'b1);
		sleep = 1'b0;
		repeat (4) @(negedge sys_clk);
		// Either depth enable off turns a write strobe into a deselect.
		depth_hi = 1'b0;
		write_lanes(3'h2, 4'h0, 1'b0, 32'hbad0_0002, 1'b0, 1'b1);
		{depth_hi, depth_lo_n} = 2'h3;
		write_lanes(3'h3, 4'h0, 1'b0, 32'hbad0_0003, 1'b0, 1'b1);
		depth_lo_n = 1'b0;
		read_burst(17'h00000, 1'b0, 1'b0);
		complete_run();
	end
endmodule : pdssp_port_bench

`default_nettype wire
